//--- common/uhs_cfg.svh
`ifndef UHS_CFG_SVH
`define UHS_CFG_SVH
// ----------------------------------------
// Register offsets and bits
// ----------------------------------------
`define UHS_OFS_CTRL 8'h00
`define UHS_OFS_SCHED 8'h04
`define UHS_OFS_TOKEN 8'h08
`define UHS_OFS_STATUS 8'h0C
`define UHS_CTRL_START 0
`define UHS_CTRL_SEND 1
`define UHS_SCHED_RST 32'h0000_0001
`define UHS_TOKEN_RST 15'h0000
// ----------------------------------------
// Link word layout
// ----------------------------------------
`define UHS_LP_T 0
`define UHS_LP_Q 1
`define UHS_LP_DF 2
`define UHS_ELEM_OFS 32'h0000_0004
// ----------------------------------------
// Line coding and timing
// ----------------------------------------
`define UHS_CLK_PS 4000
`define UHS_BIT_PS 83333
`define UHS_BIT_CYC (`UHS_BIT_PS / `UHS_CLK_PS)
`define UHS_SYNC_RAW 8'h80
`define UHS_STUFF_RUN 3'h6
`define UHS_TOK_BITS 5'h1B
`define UHS_PID_BITS 5'h10
`endif

//--- common/uhs_pkg.sv
package uhs_pkg;
  typedef enum logic [5:0] {
    SC_IDLE = 6'h01,
    SC_FTD = 6'h02,
    SC_EXEC = 6'h04,
    SC_FQH = 6'h08,
    SC_FQE = 6'h10,
    SC_WB = 6'h20
  } uhs_sched_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } uhs_mem_req_t;

  typedef struct packed {
    uhs_sched_t sc;
    logic [31:0] ptr;
    logic [31:0] head_ptr;
    logic [31:0] desc_link;
    logic [31:0] hlink;
    logic qctx;
    uhs_mem_req_t mem;
    logic exec_req;
    logic [31:0] sched_ptr;
    logic [14:0] tok;
    logic frame_done;
    logic [31:0] rdata;
    logic tx_act;
    logic [1:0] tx_eop;
    logic [26:0] tx_sh;
    logic [4:0] tx_left;
    logic [2:0] tx_ones;
    logic tx_line;
    logic [4:0] tx_cnt;
    logic tx_dp;
    logic tx_dm;
    logic tx_oe;
    logic rx_act;
    logic [4:0] rx_cnt;
    logic rx_lvl;
    logic [2:0] rx_ones;
    logic rx_sync;
    logic [2:0] rx_n;
    logic [7:0] rx_sh;
    logic rx_dead;
    logic rx_valid;
    logic rx_err;
    logic rx_stuff;
    logic [3:0] rx_pid;
  } uhs_state_t;
endpackage : uhs_pkg

//--- core/uhs_top.sv
// Behaviour
// - Outside a queue, descriptor with next-is-queue 0 and terminate 0: run, then next descriptor.
// - Outside a queue, descriptor with terminate 1: run it, then the frame ends.
// - Breadth first: run element descriptor, write back, then horizontal link or frame end.
// - Depth first: after write back follow descriptor link to descriptor or queue.
// - Element terminate set: queue empty, take horizontal link or end frame.
// - Element pointing at a queue: follow vertical link into that queue head.
// - Head pointing at a queue: horizontal link leads to another queue head.
// - NRZI: a one keeps the line level, a zero toggles it.
// - After six ones a zero is stuffed before NRZI coding.
// - Stuffing runs from SYNC on; the SYNC's last one starts a run.
// - A due stuffed zero is sent even right before end of packet.
// - Each field goes out least significant bit first.
// - Each packet opens with the eight bit SYNC, KJKJKJKK on the line.
// - PID byte is the type in bits 0-3, its complement in bits 4-7.
// - Receiver drops a packet whose PID check fails or type is undefined.
// - OUT is 0001, IN is 1001, SOF is 0101.
// - SETUP is 1101, DATA0 is 0011, DATA1 is 1011.
// - ACK 0010, NAK 1010, STALL 1110, preamble 1100.
// - PID group comes from PID bits 1 and 0.
// - IN, SETUP and OUT carry a seven bit address, bit 0 first.
// - IN, SETUP and OUT carry a four bit endpoint after the address.
// - Queue advances by write back only on a successful completion.
// - On reaching a queue head it is held and queue state recorded.
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "uhs_cfg.svh"
module uhs_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output var uhs_pkg::uhs_mem_req_t mem_out,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic exec_req,
  output logic [31:0] exec_desc,
  input wire logic exec_done,
  input wire logic exec_ok,
  input wire logic dp_in,
  input wire logic dm_in,
  output logic dp_out,
  output logic dm_out,
  output logic dp_oe,
  output logic dm_oe
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] ptr_of(input logic [31:0] link);
    ptr_of = {link[31:4], 4'h0};
  endfunction : ptr_of

  // Target by Q bit; queue state is set once the head is read
  function automatic uhs_pkg::uhs_state_t go_link(input uhs_pkg::uhs_state_t s,
                                                  input logic [31:0] link);
    go_link = s;
    go_link.ptr = ptr_of(link);
    go_link.qctx = 1'b0;
    go_link.sc = link[`UHS_LP_Q] ? uhs_pkg::SC_FQH : uhs_pkg::SC_FTD;
  endfunction : go_link

  function automatic uhs_pkg::uhs_state_t go_horiz(input uhs_pkg::uhs_state_t s);
    go_horiz = s;
    if (s.hlink[`UHS_LP_T]) begin
      go_horiz.sc = uhs_pkg::SC_IDLE;
      go_horiz.frame_done = 1'b1;
    end else begin
      go_horiz = go_link(s, s.hlink);
    end
  endfunction : go_horiz

  function automatic logic has_addr(input logic [3:0] t);
    has_addr = (t == 4'h1) || (t == 4'h9) || (t == 4'hD);
  endfunction : has_addr

  function automatic logic pid_defined(input logic [3:0] t);
    case (t)
      4'h1, 4'h9, 4'h5, 4'hD, 4'h3, 4'hB, 4'h2, 4'hA, 4'hE, 4'hC: pid_defined = 1'b1;
      default: pid_defined = 1'b0;
    endcase
  endfunction : pid_defined

  localparam logic [4:0] BIT_LAST = 5'(`UHS_BIT_CYC - 1);
  localparam logic [4:0] BIT_HALF = 5'(`UHS_BIT_CYC / 2);

  uhs_pkg::uhs_state_t s_r;
  uhs_pkg::uhs_state_t s_nxt;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic b;
    logic [7:0] pid;
    uhs_pkg::uhs_state_t n;
    b = 1'b0;
    pid = 8'h00;
    n = s_r;
    n.rdata = 32'h0000_0000;
    n.exec_req = 1'b0;
    n.mem.req = 1'b0;
    n.mem.we = 1'b0;

    // Register writes; clears come first so hardware sets below win
    if (reg_wr) begin
      if (reg_addr == `UHS_OFS_CTRL) begin
        if (reg_wdata[`UHS_CTRL_START] && s_r.sc == uhs_pkg::SC_IDLE) begin
          if (s_r.sched_ptr[`UHS_LP_T]) begin
            n.frame_done = 1'b1;
          end else begin
            n = go_link(n, s_r.sched_ptr);
          end
        end
        if (reg_wdata[`UHS_CTRL_SEND] && !s_r.tx_act) begin
          n.tx_act = 1'b1;
          n.tx_oe = 1'b1;
          n.tx_dp = 1'b1;
          n.tx_dm = 1'b0;
          n.tx_line = 1'b1;
          n.tx_cnt = 5'h00;
          n.tx_ones = 3'h0;
          n.tx_eop = 2'h0;
          n.tx_sh = {s_r.tok[14:11], s_r.tok[10:4], ~s_r.tok[3:0], s_r.tok[3:0],
                     `UHS_SYNC_RAW};
          n.tx_left = has_addr(s_r.tok[3:0]) ? `UHS_TOK_BITS : `UHS_PID_BITS;
        end
      end else if (reg_addr == `UHS_OFS_SCHED) begin
        n.sched_ptr = reg_wdata;
      end else if (reg_addr == `UHS_OFS_TOKEN) begin
        n.tok = reg_wdata[14:0];
      end else if (reg_addr == `UHS_OFS_STATUS) begin
        if (reg_wdata[1]) n.frame_done = 1'b0;
        if (reg_wdata[3]) n.rx_valid = 1'b0;
        if (reg_wdata[4]) n.rx_err = 1'b0;
        if (reg_wdata[5]) n.rx_stuff = 1'b0;
      end
    end
    if (reg_rd) begin
      if (reg_addr == `UHS_OFS_SCHED) begin
        n.rdata = s_r.sched_ptr;
      end else if (reg_addr == `UHS_OFS_TOKEN) begin
        n.rdata = {17'h00000, s_r.tok};
      end else if (reg_addr == `UHS_OFS_STATUS) begin
        n.rdata = {18'h00000, s_r.rx_pid[1:0], s_r.rx_pid, 1'b0, s_r.qctx,
                   s_r.rx_stuff, s_r.rx_err, s_r.rx_valid, s_r.tx_act,
                   s_r.frame_done, s_r.sc != uhs_pkg::SC_IDLE};
      end
    end

    // Schedule walk
    case (s_r.sc)
      uhs_pkg::SC_FTD: begin
        n.mem.addr = s_r.ptr;
        if (mem_ack) begin
          n.desc_link = mem_rdata;
          n.exec_req = 1'b1;
          n.sc = uhs_pkg::SC_EXEC;
        end else begin
          n.mem.req = 1'b1;
        end
      end
      uhs_pkg::SC_EXEC: begin
        if (exec_done) begin
          if (!s_r.qctx) begin
            if (s_r.desc_link[`UHS_LP_T]) begin
              n.sc = uhs_pkg::SC_IDLE;
              n.frame_done = 1'b1;
            end else begin
              n = go_link(n, s_r.desc_link);
            end
          end else if (exec_ok) begin
            n.sc = uhs_pkg::SC_WB;
          end else begin
            n = go_horiz(n);
          end
        end
      end
      uhs_pkg::SC_WB: begin
        n.mem.addr = s_r.head_ptr + `UHS_ELEM_OFS;
        n.mem.wdata = s_r.desc_link;
        n.mem.we = 1'b1;
        if (mem_ack) begin
          n.mem.we = 1'b0;
          if (s_r.desc_link[`UHS_LP_DF] && !s_r.desc_link[`UHS_LP_T]) begin
            // depth first; new element equals the descriptor link
            if (s_r.desc_link[`UHS_LP_Q]) begin
              n = go_link(n, s_r.desc_link);
            end else begin
              n.sc = uhs_pkg::SC_FQE;
            end
          end else begin
            n = go_horiz(n);
          end
        end else begin
          n.mem.req = 1'b1;
        end
      end
      uhs_pkg::SC_FQH: begin
        n.mem.addr = s_r.ptr;
        if (mem_ack) begin
          n.hlink = mem_rdata;
          n.head_ptr = s_r.ptr;
          n.qctx = 1'b1;
          n.sc = uhs_pkg::SC_FQE;
        end else begin
          n.mem.req = 1'b1;
        end
      end
      uhs_pkg::SC_FQE: begin
        n.mem.addr = s_r.head_ptr + `UHS_ELEM_OFS;
        if (mem_ack) begin
          if (mem_rdata[`UHS_LP_T]) begin
            n = go_horiz(n);
          end else if (mem_rdata[`UHS_LP_Q]) begin
            n = go_link(n, mem_rdata);
          end else begin
            n.ptr = ptr_of(mem_rdata);
            n.sc = uhs_pkg::SC_FTD;
          end
        end else begin
          n.mem.req = 1'b1;
        end
      end
      default: begin
      end
    endcase

    // Transmit serialiser, one line bit per bit period
    if (s_r.tx_act) begin
      if (s_r.tx_cnt != 5'h00) begin
        n.tx_cnt = s_r.tx_cnt - 5'h01;
      end else begin
        n.tx_cnt = BIT_LAST;
        if (s_r.tx_eop == 2'h1) begin
          n.tx_eop = 2'h2;
        end else if (s_r.tx_eop == 2'h2) begin
          n.tx_eop = 2'h3;
          n.tx_dp = 1'b1;
          n.tx_dm = 1'b0;
        end else if (s_r.tx_eop == 2'h3) begin
          n.tx_act = 1'b0;
          n.tx_oe = 1'b0;
          n.tx_dp = 1'b0;
          n.tx_eop = 2'h0;
        end else if (s_r.tx_ones == `UHS_STUFF_RUN) begin
          n.tx_line = ~s_r.tx_line;
          n.tx_ones = 3'h0;
          n.tx_dp = ~s_r.tx_line;
          n.tx_dm = s_r.tx_line;
        end else if (s_r.tx_left != 5'h00) begin
          b = s_r.tx_sh[0];
          n.tx_sh = {1'b0, s_r.tx_sh[26:1]};
          n.tx_left = s_r.tx_left - 5'h01;
          n.tx_line = b ? s_r.tx_line : ~s_r.tx_line;
          n.tx_ones = b ? s_r.tx_ones + 3'h1 : 3'h0;
          n.tx_dp = n.tx_line;
          n.tx_dm = ~n.tx_line;
        end else begin
          n.tx_eop = 2'h1;
          n.tx_dp = 1'b0;
          n.tx_dm = 1'b0;
        end
      end
    end

    // Receiver; samples mid-bit from the first K, no re-alignment on edges
    if (!s_r.rx_act) begin
      if (!s_r.tx_oe && !dp_in && dm_in) begin
        n.rx_act = 1'b1;
        n.rx_cnt = BIT_HALF;
        n.rx_lvl = 1'b1;
        n.rx_ones = 3'h0;
        n.rx_sync = 1'b0;
        n.rx_n = 3'h0;
        n.rx_dead = 1'b0;
      end
    end else if (s_r.rx_cnt != 5'h00) begin
      n.rx_cnt = s_r.rx_cnt - 5'h01;
    end else if (!dp_in && !dm_in) begin
      n.rx_act = 1'b0;
    end else begin
      n.rx_cnt = BIT_LAST;
      n.rx_lvl = dp_in;
      b = (dp_in == s_r.rx_lvl);
      if (s_r.rx_dead) begin
        n.rx_dead = 1'b1;
      end else if (s_r.rx_ones == `UHS_STUFF_RUN) begin
        // drop stuffed zero or flag the seventh one
        n.rx_ones = 3'h0;
        if (b) begin
          n.rx_stuff = 1'b1;
          n.rx_dead = 1'b1;
        end
      end else begin
        n.rx_ones = b ? s_r.rx_ones + 3'h1 : 3'h0;
        if (!s_r.rx_sync) begin
          n.rx_sync = b;
        end else begin
          pid = {b, s_r.rx_sh[7:1]};
          n.rx_sh = pid;
          n.rx_n = s_r.rx_n + 3'h1;
          if (s_r.rx_n == 3'h7) begin
            n.rx_dead = 1'b1;
            n.rx_pid = pid[3:0];
            if (pid[7:4] == ~pid[3:0] && pid_defined(pid[3:0])) begin
              n.rx_valid = 1'b1;
            end else begin
              n.rx_err = 1'b1;
            end
          end
        end
      end
    end
    s_nxt = n;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.sc <= uhs_pkg::SC_IDLE;
      s_r.sched_ptr <= `UHS_SCHED_RST;
      s_r.tok <= `UHS_TOKEN_RST;
      s_r.tx_line <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign mem_out = s_r.mem;
  assign exec_req = s_r.exec_req;
  assign exec_desc = s_r.ptr;
  assign dp_out = s_r.tx_dp;
  assign dm_out = s_r.tx_dm;
  assign dp_oe = s_r.tx_oe;
  assign dm_oe = s_r.tx_oe;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_desc_next_link: assert property (
    (s_r.sc == uhs_pkg::SC_EXEC && exec_done && !s_r.qctx && !s_r.desc_link[0]
     && !s_r.desc_link[1]) |=> (s_r.sc == uhs_pkg::SC_FTD && s_r.ptr[31:4]
     == $past(s_r.desc_link[31:4]))) else $error("Descriptor link not followed");
  a_desc_frame_end: assert property (
    (s_r.sc == uhs_pkg::SC_EXEC && exec_done && !s_r.qctx && s_r.desc_link[0])
    |=> (s_r.sc == uhs_pkg::SC_IDLE && s_r.frame_done)) else $error("Frame not ended");
  a_queue_empty: assert property (
    (s_r.sc == uhs_pkg::SC_FQE && mem_ack && mem_rdata[0] && s_r.hlink[0])
    |=> s_r.sc == uhs_pkg::SC_IDLE ##1 !s_r.exec_req) else $error("Empty queue ran");
  a_no_adv_err: assert property (
    (s_r.sc == uhs_pkg::SC_EXEC && exec_done && !exec_ok)
    |=> !s_r.mem.we [*2]) else $error("Queue advanced on error");
  a_head_held: assert property (
    (s_r.sc == uhs_pkg::SC_FQE) |-> s_r.qctx) else $error("Queue state lost");
  a_nrzi_level: assert property (
    (s_r.tx_act && s_r.tx_cnt == 5'h00 && s_r.tx_eop == 2'h0 && s_r.tx_ones != 3'h6
     && s_r.tx_left != 5'h00) |=> (s_r.tx_line == ($past(s_r.tx_sh[0]) ?
     $past(s_r.tx_line) : !$past(s_r.tx_line)))) else $error("NRZI level wrong");
  a_stuff_before_eop: assert property (
    (s_r.tx_act && s_r.tx_cnt == 5'h00 && s_r.tx_eop == 2'h0 && s_r.tx_ones == 3'h6)
    |=> (s_r.tx_eop == 2'h0 && s_r.tx_ones == 3'h0 && s_r.tx_line != $past(s_r.tx_line)))
    else $error("Stuff bit missing");
  a_pid_check: assert property (
    $rose(s_r.tx_act) |-> (s_r.tx_sh[15:12] == ~s_r.tx_sh[11:8]
    && s_r.tx_sh[7:0] == `UHS_SYNC_RAW)) else $error("PID byte malformed");
  a_token_len: assert property (
    $rose(s_r.tx_act) |-> (s_r.tx_left == (has_addr(s_r.tx_sh[11:8]) ? 5'h1B : 5'h10)))
    else $error("Token length wrong");
endmodule : uhs_top
`default_nettype wire

//--- verif/uhs_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module uhs_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire uhs_pkg::uhs_mem_req_t mem_out,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  input wire logic exec_req,
  output logic exec_done,
  output logic exec_ok,
  input wire logic ok_cfg,
  input wire logic slow
);
  // --------
  // Host memory and executor
  // --------
  logic [31:0] words [0:15];
  logic [31:0] wb_cnt;
  logic [31:0] wb_addr;
  logic [31:0] wb_data;
  logic [3:0] wait_r;
  logic [3:0] ewait_r;
  logic gap_r;
  logic ebusy_r;
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    exec_done <= 1'b0;
    // Idle bus toggles so stale data never passes for an answer
    mem_rdata <= ~mem_rdata;
    exec_ok <= ~ok_cfg;
    if (rst) begin
      mem_rdata <= 32'h0;
      wait_r <= 4'h0;
      gap_r <= 1'b0;
      ebusy_r <= 1'b0;
      wb_cnt <= 32'h0;
    end else begin
      // A held request is answered once only
      if (!mem_out.req) begin
        gap_r <= 1'b0;
        wait_r <= 4'h0;
      end else if (!gap_r && wait_r == (slow ? 4'h5 : 4'h0)) begin
        mem_ack <= 1'b1;
        gap_r <= 1'b1;
        wait_r <= 4'h0;
        if (mem_out.we) begin
          words[mem_out.addr[5:2]] <= mem_out.wdata;
          wb_cnt <= wb_cnt + 32'h1;
          wb_addr <= mem_out.addr;
          wb_data <= mem_out.wdata;
        end else begin
          mem_rdata <= words[mem_out.addr[5:2]];
        end
      end else if (!gap_r) begin
        wait_r <= wait_r + 4'h1;
      end
      if (exec_req && !ebusy_r) begin
        ebusy_r <= 1'b1;
        ewait_r <= slow ? 4'h7 : 4'h1;
      end else if (ebusy_r && ewait_r == 4'h0) begin
        exec_done <= 1'b1;
        exec_ok <= ok_cfg;
        ebusy_r <= 1'b0;
      end else if (ebusy_r) begin
        ewait_r <= ewait_r - 4'h1;
      end
    end
  end
endmodule : uhs_mem_model
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "uhs_cfg.svh"
module tb_top;
  logic clk, rst, reg_wr, reg_rd, mem_ack, exec_req, exec_done, exec_ok;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, mem_rdata, exec_desc, last_desc, s;
  uhs_pkg::uhs_mem_req_t mem_out;
  logic dp_in, dm_in, dp_out, dm_out, dp_oe, dm_oe;
  logic ok_cfg, slow, tb_drv, tb_dp, tb_dm;
  int n_fail, checked, n_exec;
  logic [111:0] rows [0:8];
  logic [1:0] exp_q [$];
  logic [3:0] pids [0:9] = '{4'h1, 4'h9, 4'h5, 4'hD, 4'h3, 4'hB, 4'h2, 4'hA, 4'hE, 4'hC};
  int idx [0:5] = '{0, 1, 4, 8, 9, 12};
  uhs_top dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_out(mem_out), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .exec_req(exec_req), .exec_desc(exec_desc), .exec_done(exec_done),
    .exec_ok(exec_ok), .dp_in(dp_in), .dm_in(dm_in), .dp_out(dp_out), .dm_out(dm_out),
    .dp_oe(dp_oe), .dm_oe(dm_oe)
  );
  uhs_mem_model u_mem (
    .clk(clk), .rst(rst), .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .exec_req(exec_req), .exec_done(exec_done), .exec_ok(exec_ok), .ok_cfg(ok_cfg),
    .slow(slow)
  );
  // Undriven line idles at J through the pull resistors
  assign dp_in = dp_oe ? dp_out : (tb_drv ? tb_dp : 1'b1);
  assign dm_in = dm_oe ? dm_out : (tb_drv ? tb_dm : 1'b0);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (exec_req === 1'b1) begin
      n_exec <= n_exec + 1;
      last_desc <= exec_desc;
    end
  end
  // --------
  // Shared tasks
  // --------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      n_fail++;
      finish_test();
    end
  endtask : tmo
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  // NRZI from J, stuffing counts the SYNC one
  function automatic void build(input logic [31:0] d, input int n, input bit stuff);
    logic lvl;
    int ones;
    exp_q.delete();
    lvl = 1'b1;
    ones = 0;
    for (int i = 0; i < n; i++) begin
      if (d[i]) ones++;
      else begin
        lvl = ~lvl;
        ones = 0;
      end
      exp_q.push_back({lvl, ~lvl});
      if (stuff && ones == 6) begin
        lvl = ~lvl;
        ones = 0;
        exp_q.push_back({lvl, ~lvl});
      end
    end
  endfunction : build
  function automatic logic [7:0] fld(input int r, input int f);
    return rows[r][111 - 8 * f -: 8];
  endfunction : fld
  task automatic tx_check(input logic [14:0] tok);
    int k;
    logic [3:0] t;
    t = tok[3:0];
    build({5'h00, tok[14:4], ~t, t, 8'h80}, (t == 4'h1 || t == 4'h9 || t == 4'hD) ? 27 : 16, 1);
    wr(`UHS_OFS_TOKEN, {17'h0, tok});
    wr(`UHS_OFS_CTRL, 32'h2);
    k = 0;
    while ({dp_oe, dp_out} !== 2'b10 && k < 200) begin
      wt(1);
      k++;
    end
    tmo(k, 200);
    wt(10);
    foreach (exp_q[i]) begin
      chk({29'h0, dp_oe, dp_out, dm_out}, {30'h1, exp_q[i]});
      wt(20);
    end
    chk({29'h0, dp_oe, dp_out, dm_out}, 32'h4);
    wt(20);
    chk({29'h0, dp_oe, dp_out, dm_out}, 32'h4);
    wt(20);
    chk({29'h0, dm_oe, dp_out, dm_out}, 32'h6);
    k = 0;
    while (dp_oe !== 1'b0 && k < 60) begin
      wt(1);
      k++;
    end
    tmo(k, 60);
  endtask : tx_check
  task automatic rx_send(input logic [7:0] pid, input bit stuff);
    wr(`UHS_OFS_STATUS, 32'h3A);
    build({16'h0, pid, 8'h80}, 16, stuff);
    exp_q.push_back(2'b00);
    exp_q.push_back(2'b00);
    exp_q.push_back(2'b10);
    foreach (exp_q[i]) begin
      @(posedge clk);
      tb_drv <= 1'b1;
      {tb_dp, tb_dm} <= exp_q[i];
      repeat (19) @(posedge clk);
    end
    tb_drv <= 1'b0;
    rd(`UHS_OFS_STATUS, s);
  endtask : rx_send
  // --------
  // Main sequence
  // --------
  initial begin
    int k;
    logic [31:0] wb0;
    {rst, reg_wr, reg_rd, ok_cfg, slow, tb_drv, tb_dp, tb_dm} = 8'hC0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    n_fail = 0;
    checked = 0;
    n_exec = 0;
    rows[0] = 112'h10_01_01_20_01_01_01_01_02_00_00_00_20_00;
    rows[1] = 112'h10_01_01_22_01_30_01_01_02_01_24_01_30_01;
    rows[2] = 112'h10_01_01_22_01_30_01_00_02_00_00_00_30_01;
    rows[3] = 112'h10_01_01_22_01_30_04_01_03_02_24_01_00_01;
    rows[4] = 112'h10_01_01_22_01_30_06_01_02_01_24_06_30_01;
    rows[5] = 112'h22_01_01_01_01_01_01_01_00_00_00_00_00_01;
    rows[6] = 112'h22_01_01_01_30_01_01_01_01_00_00_00_30_00;
    rows[7] = 112'h22_01_30_01_01_02_01_01_01_01_04_01_30_01;
    rows[8] = 112'h22_01_30_01_02_01_01_01_01_01_04_01_30_01;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wt(1);
    chk({29'h0, dp_oe, mem_out.req, exec_req}, 32'h0);
    rd(`UHS_OFS_SCHED, s);
    chk(s, `UHS_SCHED_RST);
    wt(1);
    chk(reg_rdata, 32'h0);
    rd(`UHS_OFS_TOKEN, s);
    chk(s, 32'h0);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, s);
    chk(s, 32'h0);
    wr(`UHS_OFS_TOKEN, 32'hFFFF_FFFF);
    rd(`UHS_OFS_TOKEN, s);
    chk(s, 32'h7FFF);
    for (int r = 0; r < 9; r++) begin
      for (int j = 0; j < 16; j++) u_mem.words[j] = 32'h1;
      for (int j = 0; j < 6; j++) u_mem.words[idx[j]] = {24'h0, fld(r, j + 1)};
      ok_cfg <= fld(r, 7) != 8'h00;
      slow <= r[0];
      n_exec = 0;
      wb0 = u_mem.wb_cnt;
      wr(`UHS_OFS_SCHED, {24'h0, fld(r, 0)});
      wr(`UHS_OFS_STATUS, 32'h2);
      wr(`UHS_OFS_CTRL, 32'h1);
      k = 0;
      s = 32'h0;
      while (s[1] !== 1'b1 && k < 400) begin
        rd(`UHS_OFS_STATUS, s);
        k++;
      end
      tmo(k, 400);
      chk(32'(n_exec), {24'h0, fld(r, 8)});
      chk(u_mem.wb_cnt - wb0, {24'h0, fld(r, 9)});
      if (fld(r, 9) != 8'h00) begin
        chk(u_mem.wb_addr, {24'h0, fld(r, 10)});
        chk(u_mem.wb_data, {24'h0, fld(r, 11)});
      end
      if (fld(r, 8) != 8'h00) chk(last_desc, {24'h0, fld(r, 12)});
      chk({30'h0, s[6], s[0]}, {23'h0, fld(r, 13), 1'b0});
    end
    foreach (pids[i]) tx_check({4'hA, 7'h55, pids[i]});
    tx_check({4'hF, 7'h60, 4'h9});
    foreach (pids[i]) begin
      rx_send({~pids[i], pids[i]}, 1'b1);
      chk(s & 32'h3F38, {18'h0, pids[i][1:0], pids[i], 8'h08});
    end
    rx_send(8'hF0, 1'b1);
    chk(s & 32'h18, 32'h10);
    rx_send(8'h22, 1'b1);
    chk(s & 32'h18, 32'h10);
    rx_send(8'hFF, 1'b1);
    chk(s & 32'h30, 32'h10);
    rx_send(8'hFF, 1'b0);
    chk(s & 32'h20, 32'h20);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
